// >>> hw/irq_vec_params.svh
`ifndef IRQ_VEC_PARAMS_SVH
`define IRQ_VEC_PARAMS_SVH

// ----------------------------------------------------------------------
// Vector slots and priorities
// ----------------------------------------------------------------------
`define VEC_RESET 7'h00
`define VEC_NMI 7'h04
`define VEC_MASK_BASE 7'h40
`define VEC_TOP_FREE 7'h78
`define PRIO_NONE 5'h00
`define PRIO_RESET 5'h01
`define PRIO_NMI 5'h02
`define PRIO_MASK_BASE 5'h03
`define TRAP_FIRST 5'h11
`define TRAP_LAST 5'h1E
`define TRAP_BIAS 5'h0F

// ----------------------------------------------------------------------
// Flag and mask layout
// ----------------------------------------------------------------------
`define FLAG_EXT0 0
`define FLAG_EXT1 1
`define FLAG_EXT2 2
`define FLAG_TIMER0 3
`define FLAG_SER0_RX 4
`define FLAG_SER0_TX 5
`define FLAG_DMA0 6
`define FLAG_TIMER1_DMA1 7
`define FLAG_EXT3 8
`define FLAG_HOST 9
`define FLAG_SER1_RX_DMA2 10
`define FLAG_SER1_TX_DMA3 11
`define FLAG_DMA4 12
`define FLAG_DMA5 13
`define FLAG_USED 14
`define FLAG_RESET_VAL 16'h0000

// ----------------------------------------------------------------------
// Shared slot selection in the DMA priority/enable control word
// ----------------------------------------------------------------------
`define SEL_DMA1 0
`define SEL_DMA2 1
`define SEL_DMA3 2

`endif

// >>> hw/irq_vec_pkg.sv
package irq_vec_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01,
    ST_DONE = 2'b11
  } svc_state_t;

  typedef enum logic [1:0] {
    SRC_RESET = 2'h0,
    SRC_NMI = 2'h1,
    SRC_TRAP = 2'h2,
    SRC_MASK = 2'h3
  } svc_src_t;

endpackage : irq_vec_pkg

// >>> hw/irq_req_if.sv
`timescale 1ns/10ps
`default_nettype none

interface irq_req_if;
  logic [15:0] flags;
  logic [13:0] pend;
  logic hit;
  logic [3:0] idx;

  modport bank(output flags);
  modport picker(input pend, output hit, idx);
  modport top(input flags, hit, idx, output pend);
endinterface : irq_req_if

`default_nettype wire

// >>> hw/irq_flag_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "irq_vec_params.svh"

module irq_flag_bank (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Set and clear strobes
  input wire logic [15:0] setVec,
  input wire logic [15:0] clrVec,
  // Flag word
  irq_req_if.bank fl
);
  import irq_vec_pkg::*;

  logic [15:0] flag_d;
  logic [15:0] flag_q;

  // ----------------------------------------------------------------------
  // One sticky flag per source; a set in the clearing cycle wins.
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_flag
      if (i < `FLAG_USED) begin : g_used
        always_comb begin
          flag_d[i] = setVec[i] | (flag_q[i] & ~clrVec[i]);
        end
      end else begin : g_rsvd
        always_comb begin
          flag_d[i] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= `FLAG_RESET_VAL;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign fl.flags = flag_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  set_beats_clear_a: assert property (
    setVec[`FLAG_EXT0] && clrVec[`FLAG_EXT0] |=> flag_q[`FLAG_EXT0])
    else $error("flag set lost against clear");

  reserved_zero_a: assert property (
    flag_q[15:14] == 2'h0)
    else $error("reserved flag bits not zero");

endmodule : irq_flag_bank

`default_nettype wire

// >>> hw/irq_priority_pick.sv
`timescale 1ns/10ps
`default_nettype none
`include "irq_vec_params.svh"

module irq_priority_pick (
  // Clock and reset, for checking only
  input wire logic core_clk,
  input wire logic rst_n,
  // Pending word and choice
  irq_req_if.picker pk
);
  import irq_vec_pkg::*;

  // ----------------------------------------------------------------------
  // Lowest pending bit has the smallest priority number and wins.
  // ----------------------------------------------------------------------
  always_comb begin
    pk.hit = 1'b0;
    pk.idx = 4'h0;
    for (int b = `FLAG_USED - 1; b >= 0; b--) begin
      if (pk.pend[b]) begin
        pk.hit = 1'b1;
        pk.idx = 4'(b);
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  lowest_wins_a: assert property (
    pk.hit |-> pk.pend[pk.idx] &&
      ((pk.pend & ((14'h0001 << pk.idx) - 14'h0001)) == 14'h0000))
    else $error("picked source is not the highest priority");

endmodule : irq_priority_pick

`default_nettype wire

// >>> hw/dsp_irq_vector.sv
`timescale 1ns/10ps
`default_nettype none
`include "irq_vec_params.svh"

// What this block does
// - Reset goes to slot 00 priority 1; nonmaskable goes to 04 priority 2.
// - External input 0 goes to slot 40, priority 3, top maskable.
// - External input 1 goes to slot 44, priority 4.
// - External input 2 goes to slot 48, priority 5.
// - External input 3 goes to slot 60, priority 11.
// - Fixed slots; timer 0 at 4C priority 6, host port at 64 priority 12.
// - Serial port 0 receive goes to slot 50, priority 7.
// - Serial port 0 transmit goes to slot 54, priority 8.
// - DMA channel 0 goes to slot 58, priority 9.
// - Slot 5C priority 10: timer 1, or DMA channel 1 when selected.
// - Slot 68 priority 13: serial 1 receive, or DMA channel 2 if selected.
// - Slot 6C priority 14: serial 1 transmit, or DMA channel 3 if selected.
// - DMA channel 4 goes to slot 70, priority 15.
// - DMA channel 5 goes to slot 74, priority 16, the lowest.
// - Flag and mask share layout: bits 0-6 as listed low sources.
// - Bits 7-13 hold the upper sources; bits 15-14 reserved, read zero.
module dsp_irq_vector (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Reset and nonmaskable requests
  input wire logic reset_input_n,
  input wire logic softResetReq,
  input wire logic nmiN,
  // External interrupt pins
  input wire logic extIrq0N,
  input wire logic extIrq1N,
  input wire logic extIrq2N,
  input wire logic extIrq3N,
  // On-chip request pulses and the DMA shared-slot select word
  input wire logic timer0Irq,
  input wire logic timer1Irq,
  input wire logic serial0RxIrq,
  input wire logic serial0TxIrq,
  input wire logic serial1RxIrq,
  input wire logic serial1TxIrq,
  input wire logic hostPortIrq,
  input wire logic [5:0] dmaChIrq,
  input wire logic [15:0] dmaPriorityEnableCtl,
  // Core side
  input wire logic [15:0] irqMaskReg,
  input wire logic intEnable,
  input wire logic [15:0] irqFlagClr,
  input wire logic softTrapReq,
  input wire logic [4:0] softTrapNumber,
  input wire logic vecAck,
  // Vector request and status
  output logic [15:0] irqFlagReg,
  output logic vecValid,
  output logic [6:0] vecSlot,
  output logic [4:0] vecPrio,
  output logic trapRefused
);
  import irq_vec_pkg::*;

  irq_req_if fl ();

  svc_state_t state_d, state_q;
  svc_src_t src_d, src_q;
  logic valid_d, valid_q;
  logic [6:0] slot_d, slot_q;
  logic [4:0] prio_d, prio_q;
  logic [3:0] bit_d, bit_q;
  logic refused_d, refused_q;
  logic [3:0] extPrev_d, extPrev_q;
  logic nmiPrev_d, nmiPrev_q;
  logic resetPend_d, resetPend_q;
  logic nmiPend_d, nmiPend_q;
  logic [3:0] extNow;
  logic [3:0] extFall;
  logic nmiFall;
  logic [15:0] setVec;
  logic [15:0] clrVec;
  logic [15:0] ackClr;
  logic resetClr;
  logic nmiClr;
  logic flagClrAll;
  logic trapOk;
  logic trapTake;
  logic maskTake;

  // ----------------------------------------------------------------------
  // Source edges and the flag set word
  // ----------------------------------------------------------------------
  assign extNow = {extIrq3N, extIrq2N, extIrq1N, extIrq0N};
  assign extFall = extPrev_q & ~extNow;
  assign nmiFall = nmiPrev_q & ~nmiN;

  always_comb begin
    setVec = 16'h0000;
    setVec[`FLAG_EXT0] = extFall[0];
    setVec[`FLAG_EXT1] = extFall[1];
    setVec[`FLAG_EXT2] = extFall[2];
    setVec[`FLAG_TIMER0] = timer0Irq;
    setVec[`FLAG_SER0_RX] = serial0RxIrq;
    setVec[`FLAG_SER0_TX] = serial0TxIrq;
    setVec[`FLAG_DMA0] = dmaChIrq[0];
    setVec[`FLAG_TIMER1_DMA1] = dmaPriorityEnableCtl[`SEL_DMA1] ?
      dmaChIrq[1] : timer1Irq;
    setVec[`FLAG_EXT3] = extFall[3];
    setVec[`FLAG_HOST] = hostPortIrq;
    setVec[`FLAG_SER1_RX_DMA2] = dmaPriorityEnableCtl[`SEL_DMA2] ?
      dmaChIrq[2] : serial1RxIrq;
    setVec[`FLAG_SER1_TX_DMA3] = dmaPriorityEnableCtl[`SEL_DMA3] ?
      dmaChIrq[3] : serial1TxIrq;
    setVec[`FLAG_DMA4] = dmaChIrq[4];
    setVec[`FLAG_DMA5] = dmaChIrq[5];
  end

  assign clrVec = irqFlagClr | ackClr | {16{flagClrAll}};
  assign fl.pend = fl.flags[13:0] & irqMaskReg[13:0];

  irq_flag_bank u_bank (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setVec(setVec),
    .clrVec(clrVec),
    .fl(fl.bank)
  );

  irq_priority_pick u_pick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pk(fl.picker)
  );

  // ----------------------------------------------------------------------
  // Reset and nonmaskable pending; a new request beats its clear.
  // ----------------------------------------------------------------------
  always_comb begin
    extPrev_d = extNow;
    nmiPrev_d = nmiN;
    resetPend_d = ~reset_input_n | softResetReq | (resetPend_q & ~resetClr);
    nmiPend_d = nmiFall | (nmiPend_q & ~nmiClr);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      extPrev_q <= 4'hF;
      nmiPrev_q <= 1'b1;
      resetPend_q <= 1'b0;
      nmiPend_q <= 1'b0;
    end else begin
      extPrev_q <= extPrev_d;
      nmiPrev_q <= nmiPrev_d;
      resetPend_q <= resetPend_d;
      nmiPend_q <= nmiPend_d;
    end
  end

  // ----------------------------------------------------------------------
  // Service sequencer
  // ----------------------------------------------------------------------
  assign trapOk = softTrapReq && softTrapNumber >= `TRAP_FIRST &&
    softTrapNumber <= `TRAP_LAST;
  assign trapTake = trapOk && state_q == ST_IDLE && !resetPend_q &&
    !nmiPend_q;
  assign maskTake = state_q == ST_IDLE && !resetPend_q && !nmiPend_q &&
    !trapOk && intEnable && fl.hit;

  always_comb begin
    state_d = state_q;
    src_d = src_q;
    valid_d = valid_q;
    slot_d = slot_q;
    prio_d = prio_q;
    bit_d = bit_q;
    refused_d = softTrapReq && !trapTake;
    ackClr = 16'h0000;
    resetClr = 1'b0;
    nmiClr = 1'b0;
    flagClrAll = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (resetPend_q) begin
          src_d = SRC_RESET;
          slot_d = `VEC_RESET;
          prio_d = `PRIO_RESET;
          valid_d = 1'b1;
          state_d = ST_REQ;
        end else if (nmiPend_q) begin
          src_d = SRC_NMI;
          slot_d = `VEC_NMI;
          prio_d = `PRIO_NMI;
          valid_d = 1'b1;
          state_d = ST_REQ;
        end else if (trapTake) begin
          src_d = SRC_TRAP;
          slot_d = {softTrapNumber - `TRAP_BIAS, 2'b00};
          prio_d = `PRIO_NONE;
          valid_d = 1'b1;
          state_d = ST_REQ;
        end else if (maskTake) begin
          src_d = SRC_MASK;
          bit_d = fl.idx;
          slot_d = 7'(`VEC_MASK_BASE + {1'b0, fl.idx, 2'b00});
          prio_d = 5'(`PRIO_MASK_BASE + {1'b0, fl.idx});
          valid_d = 1'b1;
          state_d = ST_REQ;
        end
      end
      ST_REQ: begin
        if (vecAck) begin
          valid_d = 1'b0;
          state_d = ST_DONE;
          case (src_q)
            SRC_RESET: begin
              resetClr = 1'b1;
              flagClrAll = 1'b1;
            end
            SRC_NMI: nmiClr = 1'b1;
            SRC_MASK: ackClr[bit_q] = 1'b1;
            default: ackClr = 16'h0000;
          endcase
        end
      end
      ST_DONE: state_d = ST_IDLE;
      default: begin
        state_d = ST_IDLE;
        valid_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      src_q <= SRC_RESET;
      valid_q <= 1'b0;
      slot_q <= `VEC_RESET;
      prio_q <= `PRIO_NONE;
      bit_q <= 4'h0;
      refused_q <= 1'b0;
    end else begin
      state_q <= state_d;
      src_q <= src_d;
      valid_q <= valid_d;
      slot_q <= slot_d;
      prio_q <= prio_d;
      bit_q <= bit_d;
      refused_q <= refused_d;
    end
  end

  assign irqFlagReg = fl.flags;
  assign vecValid = valid_q;
  assign vecSlot = slot_q;
  assign vecPrio = prio_q;
  assign trapRefused = refused_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence idleWith(logic c);
    state_q == ST_IDLE && c;
  endsequence

  sequence issued(logic [6:0] s, logic [4:0] p);
    vecValid && vecSlot == s && vecPrio == p;
  endsequence

  reset_slot_a: assert property (
    idleWith(resetPend_q) |=> issued(7'h00, 5'h01))
    else $error("reset not issued at slot 00 priority 1");

  nmi_slot_a: assert property (
    idleWith(!resetPend_q && nmiPend_q) |=> issued(7'h04, 5'h02))
    else $error("nmi not issued at slot 04 priority 2");

  ext0_slot_a: assert property (
    maskTake && fl.idx == 4'h0 |=> issued(7'h40, 5'h03))
    else $error("external 0 not at slot 40 priority 3");

  ext3_slot_a: assert property (
    maskTake && fl.idx == 4'h8 |=> issued(7'h60, 5'h0B))
    else $error("external 3 not at slot 60 priority 11");

  dma5_slot_a: assert property (
    maskTake && fl.idx == 4'hD |=> issued(7'h74, 5'h10))
    else $error("dma 5 not at slot 74 priority 16");

  shared_sel_a: assert property (
    dmaPriorityEnableCtl[`SEL_DMA1] && dmaChIrq[1] |=>
      irqFlagReg[`FLAG_TIMER1_DMA1])
    else $error("selected dma 1 did not set flag 7");

  ext_edge_a: assert property (
    extIrq0N ##1 !extIrq0N |=> irqFlagReg[`FLAG_EXT0])
    else $error("falling edge on external 0 not flagged");

  trap_slot_a: assert property (
    trapTake |=> vecValid && vecPrio == 5'h00 &&
      vecSlot == {$past(softTrapNumber) - 5'h0F, 2'b00})
    else $error("trap slot or priority wrong");

  no_rsvd_slot_a: assert property (
    vecValid |-> vecSlot < 7'h78)
    else $error("reserved slot issued");

  held_until_ack_a: assert property (
    vecValid && !vecAck |=> vecValid && $stable(vecSlot))
    else $error("vector dropped before acknowledge");

endmodule : dsp_irq_vector

`default_nettype wire

// >>> test/core_ack_model.sv
`timescale 1ns/10ps
`default_nettype none

module core_ack_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Vector request from the block, and the acknowledge delay setting
  input wire logic vecValid,
  input wire logic [6:0] vecSlot,
  input wire logic [4:0] vecPrio,
  input wire logic [3:0] ackDelay,
  // Acknowledge and record of what was taken
  output logic vecAck,
  output logic [6:0] lastSlot,
  output logic [4:0] lastPrio,
  output logic [7:0] ackCount
);
  logic [3:0] waitCnt;

  // ----------------------------------------------------------------
  // Core side
  // ----------------------------------------------------------------
  // The core waits ackDelay cycles, then acknowledges for one cycle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vecAck <= 1'b0;
      waitCnt <= 4'h0;
      lastSlot <= 7'h00;
      lastPrio <= 5'h00;
      ackCount <= 8'h00;
    end else if (vecAck) begin
      vecAck <= 1'b0;
      waitCnt <= 4'h0;
    end else if (vecValid) begin
      if (waitCnt == ackDelay) begin
        vecAck <= 1'b1;
        lastSlot <= vecSlot;
        lastPrio <= vecPrio;
        ackCount <= ackCount + 8'h01;
      end else begin
        waitCnt <= waitCnt + 4'h1;
      end
    end
  end
endmodule : core_ack_model

`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic core_clk, rst_n, resetInN, softResetReq, nmiN, intEnable;
  logic softTrapReq, vecAck, vecValid, trapRefused;
  logic [3:0] extIrqN, ackDelay;
  logic [6:0] periphIrq, vecSlot, lastSlot;
  logic [5:0] dmaChIrq;
  logic [15:0] dmaCtl, irqMask, irqFlagClr, irqFlagReg;
  logic [4:0] trapNum, vecPrio, lastPrio;
  logic [7:0] ackCount;
  int mismatches = 0;
  int checksDone = 0;
  int expAcks = 0;

  always #2.5 core_clk = ~core_clk;

  dsp_irq_vector i_dsp_irq_vector (.core_clk(core_clk), .rst_n(rst_n),
    .reset_input_n(resetInN), .softResetReq(softResetReq), .nmiN(nmiN),
    .extIrq0N(extIrqN[0]), .extIrq1N(extIrqN[1]), .extIrq2N(extIrqN[2]),
    .extIrq3N(extIrqN[3]), .timer0Irq(periphIrq[0]),
    .timer1Irq(periphIrq[1]), .serial0RxIrq(periphIrq[2]),
    .serial0TxIrq(periphIrq[3]), .serial1RxIrq(periphIrq[4]),
    .serial1TxIrq(periphIrq[5]), .hostPortIrq(periphIrq[6]),
    .dmaChIrq(dmaChIrq), .dmaPriorityEnableCtl(dmaCtl),
    .irqMaskReg(irqMask), .intEnable(intEnable), .irqFlagClr(irqFlagClr),
    .softTrapReq(softTrapReq), .softTrapNumber(trapNum), .vecAck(vecAck),
    .irqFlagReg(irqFlagReg), .vecValid(vecValid), .vecSlot(vecSlot),
    .vecPrio(vecPrio), .trapRefused(trapRefused));

  core_ack_model i_core_ack_model (.core_clk(core_clk), .rst_n(rst_n),
    .vecValid(vecValid), .vecSlot(vecSlot), .vecPrio(vecPrio),
    .ackDelay(ackDelay), .vecAck(vecAck), .lastSlot(lastSlot),
    .lastPrio(lastPrio), .ackCount(ackCount));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task check(input logic [15:0] seen, input logic [15:0] exp,
             input string what);
    checksDone++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s: saw %h expected %h", $time, what, seen,
               exp);
    end
  endtask : check

  task finishTest();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finishTest

  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  // Pulses the source behind flag bit b; sel picks DMA on shared bits.
  task raise(input int b, input bit sel);
    @(posedge core_clk);
    case (b)
      0, 1, 2: extIrqN[b] <= 1'b0;
      3: periphIrq[0] <= 1'b1;
      4: periphIrq[2] <= 1'b1;
      5: periphIrq[3] <= 1'b1;
      6: dmaChIrq[0] <= 1'b1;
      7: if (sel) dmaChIrq[1] <= 1'b1; else periphIrq[1] <= 1'b1;
      8: extIrqN[3] <= 1'b0;
      9: periphIrq[6] <= 1'b1;
      10: if (sel) dmaChIrq[2] <= 1'b1; else periphIrq[4] <= 1'b1;
      11: if (sel) dmaChIrq[3] <= 1'b1; else periphIrq[5] <= 1'b1;
      default: dmaChIrq[b - 8] <= 1'b1;
    endcase
    @(posedge core_clk);
    extIrqN <= 4'hF;
    periphIrq <= 7'h00;
    dmaChIrq <= 6'h00;
  endtask : raise

  // Waits for the next acknowledge and compares what the core took.
  task waitAck(input logic [6:0] slot, input logic [4:0] prio);
    int i;
    i = 0;
    while (ackCount != 8'(expAcks + 1) && i < 60) begin
      tick(1);
      i++;
    end
    expAcks++;
    if (i == 60) begin
      mismatches++;
      $display("MISMATCH %0t no vector taken", $time);
      finishTest();
    end else begin
      check({9'h000, lastSlot}, {9'h000, slot}, "slot");
      check({11'h000, lastPrio}, {11'h000, prio}, "priority");
    end
  endtask : waitAck

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task testReset();
    check(irqFlagReg, 16'h0000, "flags after reset");
    check({15'h0000, vecValid}, 16'h0000, "valid after reset");
    $display("test reset done");
  endtask : testReset

  task testTable();
    int b;
    int s;
    logic [6:0] slotTab [14];
    logic [4:0] prioTab [14];
    slotTab = '{7'h40, 7'h44, 7'h48, 7'h4C, 7'h50, 7'h54, 7'h58, 7'h5C,
                7'h60, 7'h64, 7'h68, 7'h6C, 7'h70, 7'h74};
    prioTab = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A,
                5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10};
    for (s = 0; s < 2; s++) begin
      @(posedge core_clk);
      dmaCtl <= (s == 1) ? 16'h0007 : 16'h0000;
      ackDelay <= (s == 1) ? 4'h3 : 4'h0;
      for (b = 0; b < 14; b++) begin
        @(posedge core_clk);
        irqMask <= 16'h0001 << b;
        raise(b, s[0]);
        tick(1);
        check(irqFlagReg, 16'h0001 << b, "flag set");
        waitAck(slotTab[b], prioTab[b]);
        tick(2);
        check(irqFlagReg, 16'h0000, "flag cleared by ack");
      end
    end
    $display("test vector table done");
  endtask : testTable

  task testPriority();
    @(posedge core_clk);
    intEnable <= 1'b0;
    irqMask <= 16'h3FFB;
    dmaCtl <= 16'h0000;
    ackDelay <= 4'h1;
    raise(13, 1'b0);
    raise(7, 1'b0);
    raise(2, 1'b0);
    tick(3);
    check({15'h0000, vecValid}, 16'h0000, "vector while disabled");
    check(irqFlagReg, 16'h2084, "three flags");
    @(posedge core_clk);
    intEnable <= 1'b1;
    waitAck(7'h5C, 5'h0A);
    waitAck(7'h74, 5'h10);
    tick(6);
    check({15'h0000, vecValid}, 16'h0000, "masked flag served");
    check(irqFlagReg, 16'h0004, "masked flag kept");
    @(posedge core_clk);
    irqFlagClr <= 16'hC004;
    @(posedge core_clk);
    irqFlagClr <= 16'h0000;
    tick(1);
    check(irqFlagReg, 16'h0000, "flag cleared");
    @(posedge core_clk);
    irqMask <= 16'h0000;
    extIrqN[0] <= 1'b0;
    irqFlagClr <= 16'h0001;
    @(posedge core_clk);
    extIrqN[0] <= 1'b1;
    irqFlagClr <= 16'h0000;
    tick(1);
    check(irqFlagReg, 16'h0001, "set beats clear");
    @(posedge core_clk);
    irqFlagClr <= 16'h0001;
    @(posedge core_clk);
    irqFlagClr <= 16'h0000;
    tick(1);
    check(irqFlagReg, 16'h0000, "flag 0 cleared");
    $display("test priority done");
  endtask : testPriority

  task testTraps();
    int i;
    logic seen;
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk);
      softTrapReq <= 1'b1;
      trapNum <= (i == 0) ? 5'h11 : (i == 1) ? 5'h1E : (i == 2) ? 5'h10
                 : 5'h1F;
      @(posedge core_clk);
      softTrapReq <= 1'b0;
      #1;
      seen = trapRefused;
      repeat (2) begin
        tick(1);
        seen = seen | trapRefused;
      end
      check({15'h0000, seen}, (i < 2) ? 16'h0000 : 16'h0001, "refusal");
      if (i < 2) begin
        waitAck((i == 0) ? 7'h08 : 7'h3C, 5'h00);
        tick(2);
      end else begin
        check({15'h0000, vecValid}, 16'h0000, "refused trap issued");
      end
    end
    $display("test traps done");
  endtask : testTraps

  task testResetNmi();
    @(posedge core_clk);
    intEnable <= 1'b0;
    raise(3, 1'b0);
    @(posedge core_clk);
    nmiN <= 1'b0;
    @(posedge core_clk);
    nmiN <= 1'b1;
    waitAck(7'h04, 5'h02);
    @(posedge core_clk);
    softResetReq <= 1'b1;
    @(posedge core_clk);
    softResetReq <= 1'b0;
    waitAck(7'h00, 5'h01);
    tick(2);
    check(irqFlagReg, 16'h0000, "flags after reset vector");
    @(posedge core_clk);
    resetInN <= 1'b0;
    @(posedge core_clk);
    resetInN <= 1'b1;
    waitAck(7'h00, 5'h01);
    $display("test reset and nonmaskable done");
  endtask : testResetNmi

  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    resetInN = 1'b1;
    softResetReq = 1'b0;
    nmiN = 1'b1;
    extIrqN = 4'hF;
    periphIrq = 7'h00;
    dmaChIrq = 6'h00;
    dmaCtl = 16'h0000;
    irqMask = 16'h0000;
    irqFlagClr = 16'h0000;
    intEnable = 1'b1;
    softTrapReq = 1'b0;
    trapNum = 5'h11;
    ackDelay = 4'h0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    tick(2);
    testReset();
    testTable();
    testPriority();
    testTraps();
    testResetNmi();
    finishTest();
  end
endmodule : testbench

`default_nettype wire
